// ---- verilog/tag_cmd_defs.vh ----
/*
 * Constants of the proximity tag command handler: frame codes, poll
 * request codes, status flag values, field limits and timing.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef TAG_CMD_DEFS_VH
`define TAG_CMD_DEFS_VH

// Command and response codes
`define CMD_POLL 8'h00
`define CMD_READ 8'h06
`define CMD_WRITE 8'h08
`define RSP_POLL 8'h01
`define RSP_READ 8'h07
`define RSP_WRITE 8'h09

// Poll request codes and answers
`define REQ_NONE 2'd0
`define REQ_SYSCODE 2'd1
`define REQ_PROTO 2'd2
`define PROTO_CAP 16'h0083
`define SYS_ALL 16'hffff
`define SYS_ANY_CAT 16'haaff

// Status flags
`define ST_OK 8'h00
`define ST_FAIL 8'hff
`define ERR_HOST_NORSP 8'h50
`define ERR_HOST 8'h51
`define ERR_SVC_CNT 8'ha1
`define ERR_BLK_CNT 8'ha2
`define ERR_SVC_DIFF 8'ha3
`define ERR_SELF 8'h60

// Field limits
`define READ_SVC_MAX 8'h0f
`define READ_BLK_MAX 8'h0f
`define WRITE_SVC_MAX 8'h0b
`define WRITE_SVC_SPLIT 8'h08
`define WRITE_BLK_MAX_LO 8'h0c
`define WRITE_BLK_MAX_HI 8'h0b
`define BLIST_SHORT_BIT 7

// Frame layout positions (byte index of response)
`define POS_STAT1 8'd9
`define POS_STAT2 8'd10
`define POS_BLKN 8'd11
`define POS_DATA 8'd12
`define POS_REQ 8'd17
`define LEN_STAT 8'd11

// Timing
`define HOST_TIMEOUT_NS 10000
`define CLK_PERIOD_NS 8

`endif

// ---- verilog/proximity_tag_command_handler.v ----
/*
 * Proximity tag command handler: parses poll, block-read and
 * block-write frames, checks their fields, runs memory or host
 * accesses and streams the response through a two-entry buffer.
 * Assumes framed command bytes arrive with a last marker and that the
 * memory or host answers each byte access with a one-cycle ack.
 */
// Functional notes
// - Poll answer: code, 8-byte card identifier, 8-byte time descriptor, optional data
// - Poll request code zero adds no request data
// - Poll request code one appends the configured two-byte system code
// - Poll request code two appends fixed capability value 0x0083
// - Read frame: code, identifier, service count and ids, block count, block list
// - Read service count must be 1 to 15, else error answer
// - Service id values ignored; differing ids among several give an error
// - Read block count must be 1 to 15, else error answer
// - Read answer: code, identifier, two status flags, block count, 16 bytes per block
// - Read answer drops block count and data unless status is normal end
// - Write frame: code, identifier, services, block count, list, 16 bytes per block
// - Write service count must be 1 to 11, else error answer
// - Write with 1 to 8 services accepts 1 to 12 blocks only
// - Write with 9 to 11 services accepts 1 to 11 blocks only
// - Tunnel mode sends reads and writes to the host instead of memory
// - Bad service count answers flags 0xff and 0xa1
// - Bad block count answers flags 0xff and 0xa2
`include "tag_cmd_defs.vh"
`timescale 1ns/1ns
`default_nettype none

module proximity_tag_command_handler #(
   parameter HOST_TIMEOUT = `HOST_TIMEOUT_NS / `CLK_PERIOD_NS,
   parameter MAX_BLOCKS = 15
) (
   // Clock and reset
   input wire ref_clk,
   input wire reset,
   // Command byte stream
   input wire [7:0] cmd_data,
   input wire cmd_valid,
   input wire cmd_last,
   output wire cmd_ready,
   // Response byte stream
   output wire [7:0] rsp_data,
   output wire rsp_valid,
   output wire rsp_last,
   input wire rsp_ready,
   // Configuration
   input wire [63:0] card_identifier,
   input wire [63:0] resp_time_desc,
   input wire [15:0] system_code,
   input wire tunnel_mode,
   // Byte access to memory or host
   output wire acc_req,
   output wire acc_host,
   output wire acc_write,
   output wire [15:0] acc_block,
   output wire [3:0] acc_offset,
   output wire [7:0] acc_wdata,
   input wire [7:0] acc_rdata,
   input wire acc_ack,
   input wire acc_err
);

   localparam S_CODE = 11'h001;
   localparam S_ID = 11'h002;
   localparam S_POLL = 11'h004;
   localparam S_SVCN = 11'h008;
   localparam S_SVC = 11'h010;
   localparam S_BLKN = 11'h020;
   localparam S_BLIST = 11'h040;
   localparam S_WDATA = 11'h080;
   localparam S_SKIP = 11'h100;
   localparam S_EXEC = 11'h200;
   localparam S_RESP = 11'h400;

   reg [10:0] state;
   reg [7:0] cmd;
   reg [7:0] cnt;
   reg [7:0] svc_n;
   reg [15:0] svc_first;
   reg [7:0] blk_n;
   reg [3:0] blk_i;
   reg [1:0] sub;
   reg len3;
   reg [15:0] blk_num [0:MAX_BLOCKS-1];
   reg [7:0] data [0:16*MAX_BLOCKS-1];
   reg [1:0] poll_req;
   reg [15:0] sys_in;
   reg fin;
   reg [7:0] err;
   reg [7:0] out_idx;
   reg [7:0] acc_idx;
   reg [15:0] tmo;
   reg [7:0] b_data [0:1];
   reg b_last [0:1];
   reg wr_ptr;
   reg rd_ptr;
   reg [1:0] b_cnt;

   reg [7:0] next_err;
   reg byte_done;
   reg [7:0] out_byte;
   reg [7:0] resp_len;

   wire take = cmd_valid && cmd_ready;
   wire push = (state == S_RESP) && (b_cnt != 2'd2);
   wire pop = rsp_valid && rsp_ready;
   wire is_poll = (cmd == `CMD_POLL);
   wire is_write = (cmd == `CMD_WRITE);
   // Index of the final data byte: 16 bytes per listed block, counted from zero
   wire [3:0] blk_top = blk_n[3:0] - 4'd1;
   wire [7:0] last_data = {blk_top, 4'hf};
   wire [15:0] proto_cap = `PROTO_CAP;
   wire sys_match = (sys_in == `SYS_ALL) || (sys_in == `SYS_ANY_CAT) ||
                    (sys_in == system_code);

   // Byte i of a 64-bit field, most significant first
   function [7:0] byte_of;
      input [63:0] v;
      input [2:0] i;
      begin
         byte_of = v[(7 - i) * 8 +: 8];
      end
   endfunction

   // Range test shared by all count fields
   function in_range;
      input [7:0] v;
      input [7:0] hi;
      begin
         in_range = (v != 8'h00) && (v <= hi);
      end
   endfunction

   // Field checks on the byte being taken, and end-of-command detection
   always @* begin
      next_err = `ST_OK;
      byte_done = 1'b0;
      case (state)
         S_POLL: begin
            byte_done = (cnt == 8'd3);
         end
         S_SVCN: begin
            if (!in_range(cmd_data, is_write ? `WRITE_SVC_MAX : `READ_SVC_MAX)) begin
               next_err = `ERR_SVC_CNT;
               byte_done = 1'b1;
            end
         end
         S_SVC: begin
            // Values ignored, only equality among them matters
            // Both bytes of every later id must match the first id
            if (cnt >= 8'd2 && cmd_data != (cnt[0] ? svc_first[7:0] : svc_first[15:8])) begin
               next_err = `ERR_SVC_DIFF;
            end
         end
         S_BLKN: begin
            if (is_write) begin
               if (!in_range(cmd_data, (svc_n <= `WRITE_SVC_SPLIT) ?
                             `WRITE_BLK_MAX_LO : `WRITE_BLK_MAX_HI)) begin
                  next_err = `ERR_BLK_CNT;
                  byte_done = 1'b1;
               end
            end else if (!in_range(cmd_data, `READ_BLK_MAX)) begin
               next_err = `ERR_BLK_CNT;
               byte_done = 1'b1;
            end
         end
         S_BLIST: begin
            byte_done = !is_write && ({1'b0, blk_i} == blk_n[4:0] - 5'd1) &&
                        ((sub == 2'd1 && !len3) || sub == 2'd2);
         end
         S_WDATA: begin
            byte_done = (cnt == last_data);
         end
         default: begin
            byte_done = 1'b0;
         end
      endcase
   end

   // Response length and byte at out_idx
   always @* begin
      if (is_poll) begin
         resp_len = (poll_req != `REQ_NONE) ? `POS_REQ + 8'd2 : `POS_REQ;
      end else if (!is_write && err == `ST_OK) begin
         resp_len = `POS_DATA + {blk_n[3:0], 4'h0};
      end else begin
         resp_len = `LEN_STAT;
      end
      out_byte = 8'h00;
      if (out_idx == 8'd0) begin
         out_byte = is_poll ? `RSP_POLL : (is_write ? `RSP_WRITE : `RSP_READ);
      end else if (out_idx < `POS_STAT1) begin
         out_byte = byte_of(card_identifier, out_idx[2:0] - 3'd1);
      end else if (is_poll) begin
         if (out_idx < `POS_REQ) begin
            out_byte = byte_of(resp_time_desc, out_idx[2:0] - 3'd1);
         end else if (poll_req == `REQ_SYSCODE) begin
            out_byte = (out_idx == `POS_REQ) ? system_code[15:8] : system_code[7:0];
         end else begin
            out_byte = (out_idx == `POS_REQ) ? proto_cap[15:8] : proto_cap[7:0];
         end
      end else if (out_idx == `POS_STAT1) begin
         out_byte = (err == `ST_OK) ? `ST_OK : `ST_FAIL;
      end else if (out_idx == `POS_STAT2) begin
         out_byte = err;
      end else if (out_idx == `POS_BLKN) begin
         out_byte = blk_n;
      end else begin
         out_byte = data[out_idx - `POS_DATA];
      end
   end

   // Access port is live only for a checked, error-free command
   assign acc_req = (state == S_EXEC) && (err == `ST_OK) && !is_poll;
   assign acc_host = tunnel_mode;
   assign acc_write = is_write;
   assign acc_block = blk_num[acc_idx[7:4]];
   assign acc_offset = acc_idx[3:0];
   assign acc_wdata = data[acc_idx];
   // Input stalls while a command executes or answers
   assign cmd_ready = (state != S_EXEC) && (state != S_RESP);

   // Command parse, execution and response sequencing
   always @(posedge ref_clk) begin
      if (reset) begin
         state <= S_CODE;
         cmd <= 8'h00;
         cnt <= 8'h00;
         svc_n <= 8'h00;
         svc_first <= 16'h0000;
         blk_n <= 8'h00;
         blk_i <= 4'h0;
         sub <= 2'd0;
         len3 <= 1'b0;
         poll_req <= `REQ_NONE;
         sys_in <= 16'h0000;
         fin <= 1'b0;
         err <= `ST_OK;
         out_idx <= 8'h00;
         acc_idx <= 8'h00;
         tmo <= 16'h0000;
      end else begin
         if (take) begin
            cnt <= cnt + 8'd1;
            if (err == `ST_OK) begin
               err <= next_err;
            end
            case (state)
               S_CODE: begin
                  cmd <= cmd_data;
                  cnt <= 8'h00;
                  err <= `ST_OK;
                  fin <= 1'b0;
                  poll_req <= `REQ_NONE;
                  blk_i <= 4'h0;
                  sub <= 2'd0;
                  if (cmd_data == `CMD_POLL) begin
                     state <= S_POLL;
                  end else if (cmd_data == `CMD_READ || cmd_data == `CMD_WRITE) begin
                     state <= S_ID;
                  end else begin
                     state <= S_SKIP;
                  end
               end
               S_ID: begin
                  // Identifier is accepted as sent by the reader
                  if (cnt == 8'd7) begin
                     state <= S_SVCN;
                  end
               end
               S_POLL: begin
                  if (cnt == 8'd0) begin
                     sys_in[15:8] <= cmd_data;
                  end else if (cnt == 8'd1) begin
                     sys_in[7:0] <= cmd_data;
                  end else if (cnt == 8'd2) begin
                     // Unknown request codes act as no request
                     poll_req <= (cmd_data == 8'h01) ? `REQ_SYSCODE :
                                 (cmd_data == 8'h02) ? `REQ_PROTO : `REQ_NONE;
                  end
               end
               S_SVCN: begin
                  svc_n <= cmd_data;
                  cnt <= 8'h00;
                  state <= S_SVC;
               end
               S_SVC: begin
                  if (cnt == 8'd0) begin
                     svc_first[15:8] <= cmd_data;
                  end else if (cnt == 8'd1) begin
                     svc_first[7:0] <= cmd_data;
                  end
                  if (cnt == {svc_n[6:0], 1'b0} - 8'd1) begin
                     state <= S_BLKN;
                  end
               end
               S_BLKN: begin
                  blk_n <= cmd_data;
                  state <= S_BLIST;
               end
               S_BLIST: begin
                  if (sub == 2'd0) begin
                     len3 <= !cmd_data[`BLIST_SHORT_BIT];
                     sub <= 2'd1;
                  end else begin
                     if (sub == 2'd1) begin
                        blk_num[blk_i] <= {8'h00, cmd_data};
                     end else begin
                        blk_num[blk_i][15:8] <= cmd_data;
                     end
                     if (sub == 2'd2 || !len3) begin
                        sub <= 2'd0;
                        blk_i <= blk_i + 4'd1;
                        if ({1'b0, blk_i} == blk_n[4:0] - 5'd1 && is_write) begin
                           cnt <= 8'h00;
                           state <= S_WDATA;
                        end
                     end else begin
                        sub <= 2'd2;
                     end
                  end
               end
               S_WDATA: begin
                  data[cnt] <= cmd_data;
               end
               default: begin
                  state <= state;
               end
            endcase
            // Frame end decides between answering and dropping
            if (state == S_SKIP) begin
               if (cmd_last) begin
                  state <= fin ? S_EXEC : S_CODE;
               end
            end else if (state != S_CODE) begin
               if (byte_done) begin
                  fin <= 1'b1;
                  state <= cmd_last ? S_EXEC : S_SKIP;
               end else if (cmd_last) begin
                  state <= S_CODE; // Truncated frames get no answer
               end
            end
            acc_idx <= 8'h00;
            tmo <= 16'h0000;
            out_idx <= 8'h00;
         end
         // Byte accesses run only after every check has passed
         if (state == S_EXEC) begin
            if (is_poll) begin
               state <= sys_match ? S_RESP : S_CODE;
            end else if (err != `ST_OK) begin
               state <= S_RESP;
            end else if (acc_ack) begin
               tmo <= 16'h0000;
               if (!is_write) begin
                  data[acc_idx] <= acc_rdata;
               end
               if (acc_err) begin
                  err <= tunnel_mode ? `ERR_HOST : `ERR_SELF;
                  state <= S_RESP;
               end else if (acc_idx == last_data) begin
                  state <= S_RESP;
               end else begin
                  acc_idx <= acc_idx + 8'd1;
               end
            end else if (tunnel_mode && tmo == HOST_TIMEOUT[15:0] - 16'd1) begin
               // A silent host must not hang the tag
               err <= `ERR_HOST_NORSP;
               state <= S_RESP;
            end else begin
               tmo <= tmo + 16'd1;
            end
         end
         // Response bytes enter the buffer as room allows
         if (push) begin
            out_idx <= out_idx + 8'd1;
            if (out_idx == resp_len - 8'd1) begin
               state <= S_CODE;
            end
         end
      end
   end

   // Two-entry output buffer so a stalled receiver loses no byte
   always @(posedge ref_clk) begin
      if (reset) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         b_cnt <= 2'd0;
      end else begin
         if (push) begin
            b_data[wr_ptr] <= out_byte;
            b_last[wr_ptr] <= (out_idx == resp_len - 8'd1);
            wr_ptr <= !wr_ptr;
         end
         if (pop) begin
            rd_ptr <= !rd_ptr;
         end
         b_cnt <= b_cnt + {1'b0, push} - {1'b0, pop};
      end
   end

   assign rsp_valid = (b_cnt != 2'd0);
   assign rsp_data = rsp_valid ? b_data[rd_ptr] : 8'h00;
   assign rsp_last = rsp_valid && b_last[rd_ptr];

endmodule // proximity_tag_command_handler

`default_nettype wire

// ---- dv/tag_cmd_props.sv ----
/*
 * Checker for the tag command handler: stream holding, access order, error frames.
 * Assumes binding to the top module and the constants header on the include path.
 */
`include "tag_cmd_defs.vh"
`timescale 1ns/1ns
`default_nettype none
module tag_cmd_props (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Byte streams
   input wire logic cmd_ready,
   input wire logic [7:0] rsp_data,
   input wire logic rsp_valid,
   input wire logic rsp_last,
   input wire logic rsp_ready,
   // Access port
   input wire logic tunnel_mode,
   input wire logic acc_req,
   input wire logic acc_host,
   input wire logic acc_write,
   input wire logic [15:0] acc_block,
   input wire logic [3:0] acc_offset,
   input wire logic acc_ack,
   input wire logic acc_err
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   logic [7:0] idx;
   logic [7:0] code;
   logic [7:0] flag1;
   // Track position, code and first status flag of the frame on offer
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         idx <= 8'h00;
         code <= 8'h00;
         flag1 <= 8'h00;
      end else if (rsp_valid && rsp_ready) begin
         idx <= rsp_last ? 8'h00 : idx + 8'h01;
         code <= (idx == 8'h00) ? rsp_data : code;
         flag1 <= (idx == `POS_STAT1) ? rsp_data : flag1;
      end
   end
   reset_idle_a: assert property ($fell(reset) |-> cmd_ready && !rsp_valid && !acc_req)
      else $error("outputs not idle after reset");
   rsp_hold_a: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
      else $error("response byte dropped while stalled");
   acc_hold_a: assert property (acc_req && !acc_ack |=> !acc_req || ($stable(acc_offset)
      && $stable(acc_block) && $stable(acc_write))) else $error("access changed before ack");
   acc_wait_a: assert property (acc_req && !acc_ack && !tunnel_mode |=> acc_req)
      else $error("memory access dropped before ack");
   host_route_a: assert property (acc_req |-> acc_host == tunnel_mode)
      else $error("access target differs from tunnel mode");
   acc_busy_a: assert property (acc_req |-> !cmd_ready)
      else $error("access while command stream open");
   first_code_a: assert property (rsp_valid && idx == 8'h00 |-> rsp_data == `RSP_POLL
      || rsp_data == `RSP_READ || rsp_data == `RSP_WRITE) else $error("bad response code");
   offset_step_a: assert property (acc_ack && acc_req && !acc_err && acc_offset != 4'hf |=>
      acc_req && acc_offset == $past(acc_offset) + 4'h1) else $error("access offset skipped");
   short_error_a: assert property (rsp_valid && idx == `POS_STAT2 && code != `RSP_POLL
      && flag1 == `ST_FAIL |-> rsp_last) else $error("error frame not ended at flag two");
   read_body_a: assert property (rsp_valid && idx == `POS_STAT2 && code == `RSP_READ
      && flag1 == `ST_OK |-> !rsp_last) else $error("good read frame ended early");
   // Main scenarios
   err_frame_c: cover property (rsp_valid && idx == `POS_STAT2 && flag1 == `ST_FAIL);
   host_acc_c: cover property (acc_req && acc_host && acc_ack);
   stall_c: cover property (rsp_valid && !rsp_ready);
endmodule // tag_cmd_props
`default_nettype wire

// ---- dv/acc_responder.sv ----
/*
 * Memory or host behind the access port: answers each byte after a set delay.
 * Assumes the bench sets delay, mute and fail between commands.
 */
`timescale 1ns/1ns
`default_nettype none
module acc_responder (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Access request
   input wire logic acc_req,
   input wire logic acc_host,
   input wire logic acc_write,
   input wire logic [15:0] acc_block,
   input wire logic [3:0] acc_offset,
   // Answer
   output logic [7:0] acc_rdata,
   output logic acc_ack,
   output logic acc_err,
   // Behaviour controls
   input wire logic [7:0] delay,
   input wire logic mute,
   input wire logic fail
);
   int cnt;
   // Idle read data toggles so a stale byte is never mistaken for a fresh one
   always @(posedge ref_clk) begin
      if (reset) begin
         cnt <= 0;
         acc_ack <= 1'b0;
         acc_err <= 1'b0;
         acc_rdata <= 8'h00;
      end else if (acc_req && !acc_ack && !mute && cnt >= delay) begin
         cnt <= 0;
         acc_ack <= 1'b1;
         acc_err <= fail;
         acc_rdata <= acc_write ? ~acc_rdata : acc_block[7:0] + {acc_host, 3'b000, acc_offset};
      end else begin
         cnt <= (acc_req && !acc_ack) ? cnt + 1 : 0;
         acc_ack <= 1'b0;
         acc_err <= 1'b0;
         acc_rdata <= ~acc_rdata;
      end
   end
endmodule // acc_responder
`default_nettype wire

// ---- dv/tb_top.sv ----
/*
 * Testbench: poll, read, write, field errors and tunnel traffic.
 * Assumes the handler, its constants header, the checker and responder.
 */
`include "tag_cmd_defs.vh"
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   localparam logic [63:0] id_val = 64'h0123456789abcdef;
   localparam logic [63:0] rtd_val = 64'h1f2e3d4c5b6a7988;
   localparam logic [15:0] sys_val = 16'h12fc;
   logic ref_clk, reset, cmd_valid, cmd_last, cmd_ready, rsp_valid, rsp_last, rsp_ready;
   logic tunnel_mode, acc_req, acc_host, acc_write, acc_ack, acc_err, mute, fail, stall;
   logic got_last;
   logic [7:0] cmd_data, rsp_data, acc_wdata, acc_rdata, delay, last_wd;
   logic [15:0] acc_block;
   logic [3:0] acc_offset;
   logic [7:0] fr[$], exp[$], rx[$];
   int n_mismatch, compares, cyc, n_acc;
   proximity_tag_command_handler #(.HOST_TIMEOUT(20), .MAX_BLOCKS(15))
      proximity_tag_command_handler_inst (.ref_clk(ref_clk), .reset(reset),
      .cmd_data(cmd_data), .cmd_valid(cmd_valid), .cmd_last(cmd_last), .cmd_ready(cmd_ready),
      .rsp_data(rsp_data), .rsp_valid(rsp_valid), .rsp_last(rsp_last), .rsp_ready(rsp_ready),
      .card_identifier(id_val), .resp_time_desc(rtd_val), .system_code(sys_val),
      .tunnel_mode(tunnel_mode), .acc_req(acc_req), .acc_host(acc_host),
      .acc_write(acc_write), .acc_block(acc_block), .acc_offset(acc_offset),
      .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_ack(acc_ack), .acc_err(acc_err));
   acc_responder acc_responder_inst (.ref_clk(ref_clk), .reset(reset), .acc_req(acc_req),
      .acc_host(acc_host), .acc_write(acc_write), .acc_block(acc_block),
      .acc_offset(acc_offset), .acc_rdata(acc_rdata), .acc_ack(acc_ack), .acc_err(acc_err),
      .delay(delay), .mute(mute), .fail(fail));
   // Clock, 8 ns period
   always #4 ref_clk = ~ref_clk;
   // Receiver stalls on two cycles of three when asked to
   always @(negedge ref_clk) rsp_ready = !stall || (cyc % 3 == 0);
   // Collect response bytes, count accesses, cut a hang short
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (rsp_valid && rsp_ready) begin
         rx.push_back(rsp_data);
         if (rsp_last) got_last = 1'b1;
      end
      if (acc_req && acc_ack) begin
         n_acc++;
         last_wd = acc_wdata;
         if (acc_write) cmp8("write byte", {acc_block[3:0], acc_offset}, acc_wdata);
      end
      if (cyc == 60000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      if (n_mismatch == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic cmp8(input string what, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic cmp_len(input string what, input int e, input int g);
      compares++;
      if (g != e) begin
         n_mismatch++;
         $display("mismatch %s expected %0d seen %0d", what, e, g);
      end
   endtask
   // Command frame with k as service count (one id if k is outside 1 to 15), m as count and nel list elements
   task automatic mk(input logic [7:0] cmd, input int k, input bit diff, input int m, input int nel);
      fr = {cmd};
      for (int i = 7; i >= 0; i--) fr.push_back(id_val[i*8 +: 8]);
      fr.push_back(k[7:0]);
      for (int i = 0; i < ((k > 0 && k < 16) ? k : 1); i++) begin
         fr.push_back(8'h09);
         fr.push_back((diff && i == 1) ? 8'h01 : 8'h00);
      end
      fr.push_back(m[7:0]);
      for (int b = 0; b < nel; b++) begin
         fr.push_back((b % 2 == 0) ? 8'h80 : 8'h00); // Alternate short and long elements
         fr.push_back(b[7:0]);
         if (b % 2 == 1) fr.push_back(8'h00);
      end
      if (cmd == `CMD_WRITE) for (int j = 0; j < 16 * nel; j++) fr.push_back(j[7:0]);
   endtask
   task automatic hd(input logic [7:0] code);
      exp = {code};
      for (int i = 7; i >= 0; i--) exp.push_back(id_val[i*8 +: 8]);
   endtask
   // Offer the frame, wait for the whole answer and compare it
   task automatic run();
      int t;
      rx = {};
      got_last = 1'b0;
      foreach (fr[i]) begin
         cmd_data = fr[i];
         cmd_valid = 1'b1;
         cmd_last = (i == fr.size() - 1);
         t = 0;
         while (!cmd_ready && t < 500) begin
            @(negedge ref_clk);
            t++;
         end
         @(negedge ref_clk);
      end
      cmd_valid = 1'b0;
      cmd_last = 1'b0;
      t = 0;
      while (!got_last && t < 5000) begin
         @(negedge ref_clk);
         t++;
      end
      cmp_len("response length", exp.size(), rx.size());
      foreach (exp[i]) if (i < rx.size()) cmp8("response byte", exp[i], rx[i]);
   endtask
   task automatic t_poll();
      for (int r = 0; r < 4; r++) begin
         fr = {`CMD_POLL, (r == 3) ? sys_val[15:8] : 8'hff,
               (r == 3) ? sys_val[7:0] : 8'hff, r[7:0], 8'h00};
         hd(`RSP_POLL);
         for (int i = 7; i >= 0; i--) exp.push_back(rtd_val[i*8 +: 8]);
         if (r == 1) exp = {exp, sys_val[15:8], sys_val[7:0]};
         if (r == 2) exp = {exp, 8'(`PROTO_CAP >> 8), 8'(`PROTO_CAP)};
         run();
      end
      // A foreign system code must get no answer at all
      fr = {`CMD_POLL, 8'h00, 8'h01, 8'h00, 8'h00};
      exp = {};
      run();
   endtask
   task automatic rd_ok(input int m, input logic host);
      int n0;
      tunnel_mode = host;
      mk(`CMD_READ, 2, 1'b0, m, m);
      hd(`RSP_READ);
      exp = {exp, `ST_OK, `ST_OK, m[7:0]};
      for (int b = 0; b < m; b++)
         for (int o = 0; o < 16; o++) exp.push_back(b[7:0] + {host, 3'b000, o[3:0]});
      n0 = n_acc;
      run();
      cmp_len("access count", 16 * m, n_acc - n0);
   endtask
   task automatic err1(input logic [7:0] cmd, input int k, input bit diff, input int m,
      input logic [7:0] code);
      int n0;
      mk(cmd, k, diff, m, 1);
      hd(cmd + 8'h01);
      exp = {exp, `ST_FAIL, code};
      n0 = n_acc;
      run();
      cmp_len("accesses after refusal", 0, n_acc - n0);
   endtask
   task automatic wr_ok(input int k, input int m);
      int n0;
      mk(`CMD_WRITE, k, 1'b0, m, m);
      hd(`RSP_WRITE);
      exp = {exp, `ST_OK, `ST_OK};
      n0 = n_acc;
      run();
      cmp_len("write count", 16 * m, n_acc - n0);
      cmp8("last write byte", 8'(16 * m - 1), last_wd);
   endtask
   task automatic err_acc(input logic [7:0] cmd, input logic host, input logic [7:0] code);
      tunnel_mode = host;
      mk(cmd, 1, 1'b0, 1, 1);
      hd(cmd + 8'h01);
      exp = {exp, `ST_FAIL, code};
      run();
   endtask
   initial begin
      {ref_clk, cmd_valid, cmd_last, tunnel_mode, mute, fail, stall} = '0;
      {cmd_data, delay, last_wd} = '0;
      {n_mismatch, compares, cyc, n_acc} = '0;
      rsp_ready = 1'b1;
      reset = 1'b1;
      repeat (10) @(negedge ref_clk);
      reset = 1'b0;
      t_poll();
      stall = 1'b1;
      delay = 8'h03;
      rd_ok(2, 1'b0);
      rd_ok(15, 1'b1);
      err1(`CMD_READ, 0, 1'b0, 1, `ERR_SVC_CNT);
      err1(`CMD_READ, 16, 1'b0, 1, `ERR_SVC_CNT);
      err1(`CMD_READ, 2, 1'b1, 1, `ERR_SVC_DIFF);
      err1(`CMD_READ, 1, 1'b0, 0, `ERR_BLK_CNT);
      err1(`CMD_READ, 1, 1'b0, 16, `ERR_BLK_CNT);
      err1(`CMD_WRITE, 12, 1'b0, 1, `ERR_SVC_CNT);
      err1(`CMD_WRITE, 8, 1'b0, 13, `ERR_BLK_CNT);
      err1(`CMD_WRITE, 9, 1'b0, 12, `ERR_BLK_CNT);
      stall = 1'b0;
      delay = 8'h00;
      wr_ok(8, 12);
      wr_ok(11, 11);
      fail = 1'b1;
      err_acc(`CMD_READ, 1'b1, `ERR_HOST);
      err_acc(`CMD_WRITE, 1'b0, `ERR_SELF);
      fail = 1'b0;
      mute = 1'b1;
      err_acc(`CMD_WRITE, 1'b1, `ERR_HOST_NORSP);
      report_and_stop();
   end
endmodule // tb_top
bind proximity_tag_command_handler tag_cmd_props tag_cmd_props_inst (.ref_clk(ref_clk),
   .reset(reset), .cmd_ready(cmd_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
   .rsp_last(rsp_last), .rsp_ready(rsp_ready), .tunnel_mode(tunnel_mode), .acc_req(acc_req),
   .acc_host(acc_host), .acc_write(acc_write), .acc_block(acc_block),
   .acc_offset(acc_offset), .acc_ack(acc_ack), .acc_err(acc_err));
`default_nettype wire
